// file: logic/afd_decoder.sv
`timescale 1ns/1ps
// alpha-field record decoder: byte stream in, character stream out
// Functional notes
// - first byte 80: following byte pairs are 16-bit characters, no count
// - in scheme 80, first byte of pair is the upper half
// - scheme 80 trailing FF padding and lone final byte are not emitted
// - first byte 81: second byte is the character count
// - scheme 81 base pointer is third byte shifted left by seven
// - scheme 81 bytes: top bit clear alphabet char, set base plus offset
// - first byte 82: count, then two bytes of full base pointer
// - scheme 82 bytes: top bit clear alphabet char, set base plus offset
// - counted schemes emit exactly count chars; FF inside count is valid
// - a record uses one coding only, chosen by its first byte
// - all three schemes are supported
module afd_decoder (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  in_data,
    input  wire logic        in_last,
    input  wire logic        in_valid,
    output logic             in_ready,
    output logic [15:0]      out_char,
    output logic             out_ucs2,
    output logic             out_last,
    output logic             out_valid,
    input  wire logic        out_ready
);
    import afd_pkg::*;

    function automatic logic [15:0] afd_alpha_char(input logic [7:0] b);
        return {9'h000, b[AFD_OFS_MSB:0]};
    endfunction

    afd_state_e  state_r, state_nxt;
    afd_mode_e   mode_r, mode_nxt;
    logic [7:0]  count_r, count_nxt;
    logic [15:0] base_r, base_nxt;
    logic [7:0]  hi_r, hi_nxt;
    logic        have_hi_r, have_hi_nxt;
    logic [15:0] oc_r, oc_nxt;
    logic        ou_r, ou_nxt;
    logic        ol_r, ol_nxt;
    logic        ov_r, ov_nxt;
    logic [15:0] map_char;
    logic        map_ucs2;
    logic        take;
    logic        slot_free;

    afd_symbol_map u_map (
        .body_byte    (in_data),
        .base_ptr     (base_r),
        .char_code    (map_char),
        .char_is_ucs2 (map_ucs2)
    );

    assign out_char  = oc_r;
    assign out_ucs2  = ou_r;
    assign out_last  = ol_r;
    assign out_valid = ov_r;
    // one-deep output holding stage; input stalls while it is occupied and out_ready is low
    assign slot_free = !ov_r || out_ready;
    assign in_ready  = slot_free;
    assign take      = in_valid && in_ready;

    always_comb begin
        state_nxt   = state_r;
        mode_nxt    = mode_r;
        count_nxt   = count_r;
        base_nxt    = base_r;
        hi_nxt      = hi_r;
        have_hi_nxt = have_hi_r;
        oc_nxt      = oc_r;
        ou_nxt      = ou_r;
        ol_nxt      = ol_r;
        ov_nxt      = ov_r;
        if (ov_r && out_ready) begin
            ov_nxt = 1'b0;
        end
        if (take) begin
            case (state_r)
                AFD_ST_HEAD: begin
                    have_hi_nxt = 1'b0;
                    // scheme selected by the first byte only
                    if (in_data == AFD_SCHEME_RAW) begin
                        mode_nxt  = AFD_MODE_RAW;
                        state_nxt = in_last ? AFD_ST_HEAD : AFD_ST_BODY;
                    end else if (in_data == AFD_SCHEME_HALF) begin
                        mode_nxt  = AFD_MODE_HALF;
                        state_nxt = in_last ? AFD_ST_HEAD : AFD_ST_COUNT;
                    end else if (in_data == AFD_SCHEME_FULL) begin
                        mode_nxt  = AFD_MODE_FULL;
                        state_nxt = in_last ? AFD_ST_HEAD : AFD_ST_COUNT;
                    end else begin
                        // plain alphabet record, first byte is a character
                        mode_nxt  = AFD_MODE_PLAIN;
                        oc_nxt    = afd_alpha_char(in_data);
                        ou_nxt    = 1'b0;
                        ol_nxt    = in_last;
                        ov_nxt    = 1'b1;
                        state_nxt = in_last ? AFD_ST_HEAD : AFD_ST_BODY;
                    end
                end
                AFD_ST_COUNT: begin
                    count_nxt = in_data;
                    state_nxt = in_last ? AFD_ST_HEAD : AFD_ST_BASE_HI;
                end
                AFD_ST_BASE_HI: begin
                    if (mode_r == AFD_MODE_HALF) begin
                        // bit 15 and bits 6..0 forced to zero
                        base_nxt  = 16'(in_data) << AFD_HALF_SHIFT;
                        state_nxt = in_last ? AFD_ST_HEAD : AFD_ST_BODY;
                    end else begin
                        base_nxt  = {in_data, 8'h00};
                        state_nxt = in_last ? AFD_ST_HEAD : AFD_ST_BASE_LO;
                    end
                    if (count_r == 8'h00) begin
                        state_nxt = in_last ? AFD_ST_HEAD : AFD_ST_SKIP;
                    end
                end
                AFD_ST_BASE_LO: begin
                    base_nxt  = {base_r[15:8], in_data};
                    state_nxt = in_last ? AFD_ST_HEAD : AFD_ST_BODY;
                end
                AFD_ST_BODY: begin
                    if (mode_r == AFD_MODE_PLAIN) begin
                        oc_nxt    = afd_alpha_char(in_data);
                        ou_nxt    = 1'b0;
                        ol_nxt    = in_last;
                        ov_nxt    = 1'b1;
                        state_nxt = in_last ? AFD_ST_HEAD : AFD_ST_BODY;
                    end else if (mode_r == AFD_MODE_RAW) begin
                        if (!have_hi_r) begin
                            // lone final byte is padding, never emitted
                            hi_nxt      = in_data;
                            have_hi_nxt = !in_last;
                            state_nxt   = in_last ? AFD_ST_HEAD : AFD_ST_BODY;
                        end else begin
                            have_hi_nxt = 1'b0;
                            if ({hi_r, in_data} == AFD_PAD_PAIR) begin
                                // padding reached, drop rest of record
                                state_nxt = in_last ? AFD_ST_HEAD : AFD_ST_SKIP;
                            end else begin
                                oc_nxt    = {hi_r, in_data};
                                ou_nxt    = 1'b1;
                                ol_nxt    = in_last;
                                ov_nxt    = 1'b1;
                                state_nxt = in_last ? AFD_ST_HEAD : AFD_ST_BODY;
                            end
                        end
                    end else begin
                        // FF inside count decodes as base plus 7F
                        oc_nxt    = map_char;
                        ou_nxt    = map_ucs2;
                        count_nxt = count_r - 8'h01;
                        ol_nxt    = in_last || (count_r == 8'h01);
                        ov_nxt    = 1'b1;
                        if (in_last) begin
                            state_nxt = AFD_ST_HEAD;
                        end else if (count_r == 8'h01) begin
                            state_nxt = AFD_ST_SKIP;
                        end else begin
                            state_nxt = AFD_ST_BODY;
                        end
                    end
                end
                AFD_ST_SKIP: begin
                    state_nxt = in_last ? AFD_ST_HEAD : AFD_ST_SKIP;
                end
                default: begin
                    state_nxt = AFD_ST_HEAD;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r   <= AFD_ST_HEAD;
            mode_r    <= AFD_MODE_PLAIN;
            count_r   <= 8'h00;
            base_r    <= 16'h0000;
            hi_r      <= 8'h00;
            have_hi_r <= 1'b0;
            oc_r      <= 16'h0000;
            ou_r      <= 1'b0;
            ol_r      <= 1'b0;
            ov_r      <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            mode_r    <= mode_nxt;
            count_r   <= count_nxt;
            base_r    <= base_nxt;
            hi_r      <= hi_nxt;
            have_hi_r <= have_hi_nxt;
            oc_r      <= oc_nxt;
            ou_r      <= ou_nxt;
            ol_r      <= ol_nxt;
            ov_r      <= ov_nxt;
        end
    end

    raw_pair_a: assert property (@(posedge clk) disable iff (rst)
        (take && state_r == AFD_ST_BODY && mode_r == AFD_MODE_RAW && have_hi_r
         && {hi_r, in_data} != AFD_PAD_PAIR)
        |=> (out_valid && out_ucs2 && out_char == {$past(hi_r), $past(in_data)}))
        else $error("raw pair not assembled high byte first");

    raw_pad_a: assert property (@(posedge clk) disable iff (rst)
        (take && state_r == AFD_ST_BODY && mode_r == AFD_MODE_RAW && have_hi_r
         && {hi_r, in_data} == AFD_PAD_PAIR) |=> (state_r != AFD_ST_BODY))
        else $error("decoding continued past padding pair");

    raw_odd_a: assert property (@(posedge clk) disable iff (rst)
        (take && state_r == AFD_ST_BODY && mode_r == AFD_MODE_RAW && !have_hi_r && in_last)
        |=> (!out_valid && state_r == AFD_ST_HEAD))
        else $error("lone trailing byte was emitted");

    half_base_a: assert property (@(posedge clk) disable iff (rst)
        (take && state_r == AFD_ST_BASE_HI && mode_r == AFD_MODE_HALF)
        |=> (base_r == {1'b0, $past(in_data), 7'h00}))
        else $error("half-page base pointer wrong");

    full_base_a: assert property (@(posedge clk) disable iff (rst)
        (take && state_r == AFD_ST_BASE_LO) |=> (base_r[7:0] == $past(in_data)))
        else $error("full base pointer low byte wrong");

    offset_char_a: assert property (@(posedge clk) disable iff (rst)
        (take && state_r == AFD_ST_BODY && (mode_r == AFD_MODE_HALF || mode_r == AFD_MODE_FULL)
         && in_data[AFD_FLAG_BIT])
        |=> (out_ucs2 && out_char == $past(base_r) + {9'h000, $past(in_data[AFD_OFS_MSB:0])}))
        else $error("offset character not base plus offset");

    count_end_a: assert property (@(posedge clk) disable iff (rst)
        (take && state_r == AFD_ST_BODY && mode_r != AFD_MODE_RAW && mode_r != AFD_MODE_PLAIN
         && count_r == 8'h01) |=> (out_last && state_r != AFD_ST_BODY))
        else $error("count exhausted without ending record");

    plain_pass_a: assert property (@(posedge clk) disable iff (rst)
        (take && state_r == AFD_ST_HEAD && in_data != AFD_SCHEME_RAW
         && in_data != AFD_SCHEME_HALF && in_data != AFD_SCHEME_FULL)
        |=> (out_valid && !out_ucs2 && out_char == {9'h000, $past(in_data[AFD_OFS_MSB:0])}))
        else $error("plain byte not passed through");

    out_hold_a: assert property (@(posedge clk) disable iff (rst)
        (out_valid && !out_ready) |=> (out_valid && $stable(out_char) && $stable(out_last)))
        else $error("output dropped before acceptance");

    out_once_a: assert property (@(posedge clk) disable iff (rst)
        (out_valid && out_ready && !take) |=> !out_valid)
        else $error("accepted character offered twice");

    count_load_a: assert property (@(posedge clk) disable iff (rst)
        (take && state_r == AFD_ST_COUNT) |=> (count_r == $past(in_data)))
        else $error("character count not loaded");

    count_step_a: assert property (@(posedge clk) disable iff (rst)
        (take && state_r == AFD_ST_BODY && (mode_r == AFD_MODE_HALF || mode_r == AFD_MODE_FULL))
        |=> (count_r == $past(count_r) - 8'h01))
        else $error("count not stepped per character");

    ff_valid_a: assert property (@(posedge clk) disable iff (rst)
        (take && state_r == AFD_ST_BODY && (mode_r == AFD_MODE_HALF || mode_r == AFD_MODE_FULL)
         && in_data == AFD_PAD_BYTE)
        |=> (out_valid && out_ucs2 && out_char == $past(base_r) + 16'h007F))
        else $error("FF inside count not decoded as a character");

    alpha_char_a: assert property (@(posedge clk) disable iff (rst)
        (take && state_r == AFD_ST_BODY && (mode_r == AFD_MODE_HALF || mode_r == AFD_MODE_FULL)
         && !in_data[AFD_FLAG_BIT])
        |=> (out_valid && !out_ucs2 && out_char == afd_alpha_char($past(in_data))))
        else $error("alphabet byte in counted record mis-decoded");

    head_quiet_a: assert property (@(posedge clk) disable iff (rst)
        (take && state_r == AFD_ST_HEAD && (in_data == AFD_SCHEME_RAW || in_data == AFD_SCHEME_HALF
         || in_data == AFD_SCHEME_FULL)) |=> (!out_valid && mode_r != AFD_MODE_PLAIN))
        else $error("scheme byte emitted as a character");

    hdr_quiet_a: assert property (@(posedge clk) disable iff (rst)
        (take && (state_r == AFD_ST_COUNT || state_r == AFD_ST_BASE_HI || state_r == AFD_ST_BASE_LO))
        |=> !out_valid)
        else $error("count or base byte emitted as a character");

    full_hi_a: assert property (@(posedge clk) disable iff (rst)
        (take && state_r == AFD_ST_BASE_HI && mode_r == AFD_MODE_FULL)
        |=> (base_r[15:8] == $past(in_data)))
        else $error("full base pointer high byte wrong");

    skip_quiet_a: assert property (@(posedge clk) disable iff (rst)
        (take && state_r == AFD_ST_SKIP) |=> !out_valid)
        else $error("byte after record end emitted");

    rec_end_a: assert property (@(posedge clk) disable iff (rst)
        (take && in_last) |=> (state_r == AFD_ST_HEAD))
        else $error("record end not returned to header");

    mode_hold_a: assert property (@(posedge clk) disable iff (rst)
        (state_r != AFD_ST_HEAD) |=> $stable(mode_r))
        else $error("coding changed inside a record");

    plain_body_a: assert property (@(posedge clk) disable iff (rst)
        (take && state_r == AFD_ST_BODY && mode_r == AFD_MODE_PLAIN)
        |=> (out_valid && !out_ucs2 && out_char == afd_alpha_char($past(in_data))))
        else $error("plain body byte not passed through");
endmodule

// file: logic/afd_pkg.sv
// constants and types shared by the alpha-field decoder
package afd_pkg;
    localparam logic [7:0]  AFD_SCHEME_RAW   = 8'h80;
    localparam logic [7:0]  AFD_SCHEME_HALF  = 8'h81;
    localparam logic [7:0]  AFD_SCHEME_FULL  = 8'h82;
    localparam logic [7:0]  AFD_PAD_BYTE     = 8'hFF;
    localparam logic [15:0] AFD_PAD_PAIR     = 16'hFFFF;
    localparam int          AFD_OFS_MSB      = 6;
    localparam int          AFD_HALF_SHIFT   = 7;
    localparam int          AFD_FLAG_BIT     = 7;

    typedef enum logic [2:0] {
        AFD_ST_HEAD,
        AFD_ST_COUNT,
        AFD_ST_BASE_HI,
        AFD_ST_BASE_LO,
        AFD_ST_BODY,
        AFD_ST_SKIP
    } afd_state_e;

    typedef enum logic [1:0] {
        AFD_MODE_PLAIN,
        AFD_MODE_RAW,
        AFD_MODE_HALF,
        AFD_MODE_FULL
    } afd_mode_e;
endpackage

// file: logic/afd_symbol_map.sv
`timescale 1ns/1ps
// maps one body byte of a counted record to a character
module afd_symbol_map (
    input  wire logic [7:0]  body_byte,
    input  wire logic [15:0] base_ptr,
    output logic      [15:0] char_code,
    output logic             char_is_ucs2
);
    import afd_pkg::*;

    always_comb begin
        char_is_ucs2 = body_byte[AFD_FLAG_BIT];
        if (body_byte[AFD_FLAG_BIT]) begin
            char_code = base_ptr + {9'h000, body_byte[AFD_OFS_MSB:0]};
        end else begin
            char_code = {9'h000, body_byte[AFD_OFS_MSB:0]};
        end
    end
endmodule

// file: verification/afd_byte_source.sv
// record byte source standing in for file storage
`timescale 1ns/1ps
module afd_byte_source (
    input  wire logic       clk,
    output logic      [7:0] in_data,
    output logic            in_last,
    output logic            in_valid,
    input  wire logic       in_ready
);
    initial begin
        in_data  = 8'h00;
        in_last  = 1'b0;
        in_valid = 1'b0;
    end

    // offers each byte until taken; gap idles between bytes
    task automatic send_record(input logic [7:0] rec[$], input int gap);
        logic rdy;
        @(posedge clk);
        for (int i = 0; i < rec.size(); i++) begin
            in_data  <= rec[i];
            in_last  <= (i == rec.size() - 1);
            in_valid <= 1'b1;
            rdy = 1'b0;
            while (!rdy) begin
                @(negedge clk);
                rdy = (in_ready === 1'b1);
                @(posedge clk);
            end
            if (gap > 0 || i == rec.size() - 1) begin
                in_valid <= 1'b0;
                in_last  <= 1'b0;
                in_data  <= ~rec[i];
                repeat (gap) @(posedge clk);
            end
        end
    endtask
endmodule

// file: verification/alpha_field_ucs2_decoder_tb_top.sv
// self-checking bench for the alpha-field decoder
`timescale 1ns/1ps
module alpha_field_ucs2_decoder_tb_top;
    import afd_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  in_data;
    logic        in_last;
    logic        in_valid;
    logic        in_ready;
    logic [15:0] out_char;
    logic        out_ucs2;
    logic        out_last;
    logic        out_valid;
    logic        out_ready = 1'b1;
    logic        stall_en = 1'b0;
    logic [15:0] cyc = 16'h0000;
    int          mismatches = 0;
    int          tests_run = 0;
    logic [17:0] got[$];
    logic [7:0]  r[$];
    logic [17:0] e[$];

    afd_byte_source src (.clk(clk), .in_data(in_data), .in_last(in_last), .in_valid(in_valid),
        .in_ready(in_ready));
    afd_decoder DUT (.clk(clk), .rst(rst), .in_data(in_data), .in_last(in_last),
        .in_valid(in_valid), .in_ready(in_ready), .out_char(out_char), .out_ucs2(out_ucs2),
        .out_last(out_last), .out_valid(out_valid), .out_ready(out_ready));

    always #50 clk = ~clk;

    always @(posedge clk) begin
        cyc       <= cyc + 16'h0001;
        out_ready <= !stall_en || (cyc[1:0] != 2'h0);
        if (cyc == 16'h4E20) begin
            mismatches++;
            $display("[FAIL] %0t timeout", $time);
            tally_and_finish();
        end
    end

    // a transfer seen here completes at the following rising edge
    always @(negedge clk) begin
        if (!rst && out_valid === 1'b1 && out_ready === 1'b1)
            got.push_back({out_char, out_ucs2, out_last});
    end

    function automatic logic [17:0] mk(input logic [15:0] c, input logic u, input logic l);
        return {c, u, l};
    endfunction

    task automatic run_record(input int gap);
        int n;
        got.delete();
        src.send_record(r, gap);
        n = 0;
        while (got.size() < e.size() && n < 200) begin
            @(posedge clk);
            n++;
        end
        repeat (8) @(posedge clk);
        tests_run++;
        if (got.size() != e.size()) begin
            mismatches++;
            $display("[FAIL] %0t got %0d chars, want %0d", $time, got.size(), e.size());
        end else begin
            foreach (e[i]) begin
                tests_run++;
                if (got[i] !== e[i]) begin
                    mismatches++;
                    $display("[FAIL] %0t char %0d got %h want %h", $time, i, got[i], e[i]);
                end
            end
        end
    endtask

    task automatic t_reset;
        @(negedge clk);
        tests_run++;
        if (out_valid !== 1'b0 || in_ready !== 1'b1 || out_char !== 16'h0000 || out_ucs2 !== 1'b0
            || out_last !== 1'b0) begin
            mismatches++;
            $display("[FAIL] %0t outputs wrong in reset", $time);
        end
    endtask

    task automatic t_raw;
        r = {8'h80, 8'h41, 8'h42, 8'h04, 8'h30, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
        e = {mk(16'h4142, 1'b1, 1'b0), mk(16'h0430, 1'b1, 1'b0)};
        run_record(0);
        r = {8'h80, 8'hFF, 8'h41, 8'hFF};
        e = {mk(16'hFF41, 1'b1, 1'b0)};
        run_record(1);
    endtask

    task automatic t_half;
        stall_en <= 1'b1;
        r = {8'h81, 8'h05, 8'h13, 8'h53, 8'h95, 8'hA6, 8'h4E, 8'hFF, 8'hFF};
        e = {mk(16'h0053, 1'b0, 1'b0), mk(16'h0995, 1'b1, 1'b0), mk(16'h09A6, 1'b1, 1'b0),
             mk(16'h004E, 1'b0, 1'b0), mk(16'h09FF, 1'b1, 1'b1)};
        run_record(0);
    endtask

    task automatic t_full;
        r = {8'h82, 8'h05, 8'h05, 8'h30, 8'h2D, 8'h82, 8'hD3, 8'h2D, 8'h31};
        e = {mk(16'h002D, 1'b0, 1'b0), mk(16'h0532, 1'b1, 1'b0), mk(16'h0583, 1'b1, 1'b0),
             mk(16'h002D, 1'b0, 1'b0), mk(16'h0031, 1'b0, 1'b1)};
        run_record(2);
    endtask

    task automatic t_plain;
        stall_en <= 1'b0;
        r = {8'h41, 8'hC2, 8'h00};
        e = {mk(16'h0041, 1'b0, 1'b0), mk(16'h0042, 1'b0, 1'b0), mk(16'h0000, 1'b0, 1'b1)};
        run_record(0);
    endtask

    task automatic t_counts;
        stall_en <= 1'b1;
        r = {8'h81, 8'h00, 8'h13, 8'h95};
        e = {};
        run_record(0);
        r = {8'h82, 8'h01, 8'h00, 8'h00, 8'hC1, 8'h41};
        e = {mk(16'h0041, 1'b1, 1'b1)};
        run_record(0);
        r = {8'h81, 8'h01, 8'hFF, 8'h81};
        e = {mk(16'h7F81, 1'b1, 1'b1)};
        run_record(0);
    endtask

    task automatic tally_and_finish;
        $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (15) @(posedge clk);
        t_reset();
        @(posedge clk);
        rst <= 1'b0;
        t_raw();
        t_half();
        t_full();
        t_plain();
        t_counts();
        tally_and_finish();
    end
endmodule
